// file: src/pfmux_top.v
`include "pfmux_consts.vh"
// Function
// - the wide port carries a 16-bit address and then data for external accesses.
// - an address latch strobe marks the address phase so outside logic can latch it.
// - read and write strobes signal accesses; byte or word comes from high byte select and A0.
// - the general port is 16 bits, 12 of them I/O and bits 10, 11, 12, 15 the bus strobes.
// - a function register picks plain I/O or the alternate function for each I/O pin.
// - in extended addressing, bits 8, 9, 13, 14 carry the bank number, bit 8 the lsb.
// - the 8-bit interrupt input port is readable and also feeds its peripheral functions.
// - the serial channel port gives enables, receive inputs and transmit outputs.
// - every serial channel port pin can be read by software at any time.
// - serial port bit 0 serves as receiver enable, frame sync or receiver clock by config.
// - the bidirectional port has a per-pin direction register.
// - its data register is driven onto the pins set as outputs.
// - reading the pin address returns the real pin levels.
// - an inverted copy of the clock and a half-rate clock are driven out.
// - the ready/hold pin is ready or hold request by a software bit; in hold mode I4 is ready.
module pfmux_top (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // address/data port
  input wire [15:0] portAIn,
  output reg [15:0] portAOut,
  output reg portAOe,
  // general port with alternate functions
  input wire [15:0] portBIn,
  output reg [15:0] portBOut,
  output reg [15:0] portBOe,
  input wire [15:0] altOut,
  input wire [15:0] altOe,
  output wire [15:0] portBSync,
  // interrupt input port and ready/hold
  input wire [7:0] portIIn,
  output wire [7:0] portISync,
  input wire readyOrHoldRequest,
  output reg holdAcknowledgeOut,
  // serial channel port
  input wire [7:0] portDIn,
  output reg [7:0] portDOut,
  output reg [7:0] portDOe,
  input wire txOneData,
  input wire txOneDrive,
  input wire txTwoData,
  input wire txTwoDrive,
  output wire [7:0] portDSync,
  output reg receiverOneEnable,
  output reg decoderFrameSync,
  output reg receiverOneClock,
  // bidirectional port
  input wire [7:0] portRIn,
  output reg [7:0] portROut,
  output reg [7:0] portROe,
  // derived clocks
  output wire invertedClockOut,
  output reg halfRateClockOut
);
  // ==========================================
  // declarations
  reg [15:0] portBData;
  reg [15:0] portBDir;
  reg [15:0] portFunctionSelect;
  reg [7:0] portRData;
  reg [7:0] portRDir;
  reg extMode;
  reg [3:0] bankNumber;
  reg holdMode;
  reg [1:0] sharedSel;
  reg [15:0] xAddr;
  reg [15:0] xWdata;
  reg xPending;
  reg xWrite;
  reg xByte;
  reg holdAck;
  reg [31:0] next_rdata;
  reg [15:0] next_portBOut;
  reg [15:0] next_portBOe;
  wire [15:0] portASync;
  wire [7:0] portRSync;
  wire readyHoldSync;
  wire busReq;
  wire busWr;
  wire busRd;
  wire holdWanted;
  wire engReady;
  wire engStart;
  wire engBusy;
  wire [15:0] engRdata;
  wire engAle;
  wire engRdN;
  wire engWrN;
  wire engHbe;
  wire [15:0] engAdOut;
  wire engAdOe;
  integer i;

  // merge written byte lanes into a 16-bit register
  function [15:0] laneMerge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0] sel;
    begin
      laneMerge16 = old;
      if (sel[0]) begin
        laneMerge16[7:0] = data[7:0];
      end
      if (sel[1]) begin
        laneMerge16[15:8] = data[15:8];
      end
    end
  endfunction

  // ==========================================
  // pin synchronisers
  pfmux_pin_sync #(
    .WIDTH(57)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn({readyOrHoldRequest, portRIn, portDIn, portIIn, portBIn, portAIn}),
    .pinSync({readyHoldSync, portRSync, portDSync, portISync, portBSync, portASync})
  );

  // ==========================================
  // wishbone decode
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr = busReq & wb_we_i;
  assign busRd = busReq & ~wb_we_i;

  // single-wait ack, dropped the cycle after
  always @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busRd) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // read mux; pin addresses show synced pin levels
  always @* begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `PFMUX_OFF_B_DATA: next_rdata[15:0] = portBData;
      `PFMUX_OFF_B_DIR: next_rdata[15:0] = portBDir;
      `PFMUX_OFF_B_FUNC: next_rdata[15:0] = portFunctionSelect;
      `PFMUX_OFF_R_DATA: next_rdata[7:0] = portRData;
      `PFMUX_OFF_R_DIR: next_rdata[7:0] = portRDir;
      `PFMUX_OFF_R_PINS: next_rdata[7:0] = portRSync;
      `PFMUX_OFF_I_PINS: next_rdata[7:0] = portISync;
      `PFMUX_OFF_D_PINS: next_rdata[7:0] = portDSync;
      `PFMUX_OFF_B_PINS: next_rdata[15:0] = portBSync;
      `PFMUX_OFF_CTRL: next_rdata[7:0] = {sharedSel, holdMode, bankNumber, extMode};
      `PFMUX_OFF_X_ADDR: next_rdata[15:0] = xAddr;
      `PFMUX_OFF_X_DATA: next_rdata[15:0] = engRdata;
      `PFMUX_OFF_X_CMD: begin
        next_rdata[`PFMUX_STAT_BUSY] = xPending | engBusy;
        next_rdata[`PFMUX_STAT_HOLDA] = holdAck;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ==========================================
  // software registers
  always @(posedge clk) begin
    if (sys_rst) begin
      portBData <= `PFMUX_RST16;
      portBDir <= `PFMUX_RST16;
      portFunctionSelect <= `PFMUX_RST16;
      portRData <= `PFMUX_RST8;
      portRDir <= `PFMUX_RST8;
      extMode <= 1'b0;
      bankNumber <= 4'h0;
      holdMode <= 1'b0;
      sharedSel <= `PFMUX_D0_ENABLE;
      xAddr <= `PFMUX_RST16;
      xWdata <= `PFMUX_RST16;
    end else if (busWr) begin
      case (wb_adr_i)
        `PFMUX_OFF_B_DATA: portBData <= laneMerge16(portBData, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PFMUX_OFF_B_DIR: portBDir <= laneMerge16(portBDir, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PFMUX_OFF_B_FUNC: begin
          portFunctionSelect <= laneMerge16(portFunctionSelect, wb_dat_i[15:0],
            wb_sel_i[1:0]);
        end
        `PFMUX_OFF_R_DATA: begin
          if (wb_sel_i[0]) begin
            portRData <= wb_dat_i[7:0];
          end
        end
        `PFMUX_OFF_R_DIR: begin
          if (wb_sel_i[0]) begin
            portRDir <= wb_dat_i[7:0];
          end
        end
        `PFMUX_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            extMode <= wb_dat_i[`PFMUX_CTRL_EXT];
            bankNumber <= wb_dat_i[`PFMUX_CTRL_BANK_LO +: 4];
            holdMode <= wb_dat_i[`PFMUX_CTRL_HOLD];
            sharedSel <= wb_dat_i[`PFMUX_CTRL_D0SEL_LO +: 2];
          end
        end
        `PFMUX_OFF_X_ADDR: xAddr <= laneMerge16(xAddr, wb_dat_i[15:0], wb_sel_i[1:0]);
        `PFMUX_OFF_X_DATA: xWdata <= laneMerge16(xWdata, wb_dat_i[15:0], wb_sel_i[1:0]);
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // external access launch and hold arbitration
  assign holdWanted = holdMode & readyHoldSync;
  assign engStart = xPending & ~holdAck & ~holdWanted;
  // ready comes from I4 in hold mode, else the shared pin
  assign engReady = holdMode ? portISync[`PFMUX_I_RDY] : readyHoldSync;

  // command is refused while an access is pending or running
  always @(posedge clk) begin
    if (sys_rst) begin
      xPending <= 1'b0;
      xWrite <= 1'b0;
      xByte <= 1'b0;
      holdAck <= 1'b0;
    end else begin
      if (busWr && wb_adr_i == `PFMUX_OFF_X_CMD && wb_sel_i[0] &&
          wb_dat_i[`PFMUX_CMD_START] && !xPending && !engBusy) begin
        xPending <= 1'b1;
        xWrite <= wb_dat_i[`PFMUX_CMD_WRITE];
        xByte <= wb_dat_i[`PFMUX_CMD_BYTE];
      end else if (engStart) begin
        xPending <= 1'b0;
      end
      // hold granted only between accesses
      holdAck <= holdWanted & (holdAck | ~engBusy);
    end
  end

  pfmux_ext_bus #(
    .TAIL(`PFMUX_TAIL_CYCLES)
  ) u_bus (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(engStart),
    .writeAcc(xWrite),
    .byteAcc(xByte),
    .addr(xAddr),
    .wdata(xWdata),
    .ready(engReady),
    .adIn(portASync),
    .busy(engBusy),
    .rdata(engRdata),
    .ale(engAle),
    .readStrobeN(engRdN),
    .writeStrobeN(engWrN),
    .highByteSelect(engHbe),
    .adOut(engAdOut),
    .adOe(engAdOe)
  );

  // ==========================================
  // general port pin mux
  always @* begin
    for (i = 0; i < 16; i = i + 1) begin
      if (portFunctionSelect[i]) begin
        next_portBOut[i] = altOut[i];
        next_portBOe[i] = altOe[i];
      end else begin
        next_portBOut[i] = portBData[i];
        next_portBOe[i] = portBDir[i];
      end
    end
    // bank number overrides the timer outputs
    if (extMode) begin
      next_portBOut[`PFMUX_B_BS0] = bankNumber[0];
      next_portBOut[`PFMUX_B_BS1] = bankNumber[1];
      next_portBOut[`PFMUX_B_BS2] = bankNumber[2];
      next_portBOut[`PFMUX_B_BS3] = bankNumber[3];
      next_portBOe[`PFMUX_B_BS0] = 1'b1;
      next_portBOe[`PFMUX_B_BS1] = 1'b1;
      next_portBOe[`PFMUX_B_BS2] = 1'b1;
      next_portBOe[`PFMUX_B_BS3] = 1'b1;
    end
    if (holdMode) begin
      next_portBOut[`PFMUX_B_HOLDA] = holdAck;
      next_portBOe[`PFMUX_B_HOLDA] = 1'b1;
    end
    // bus strobes float while the bus is held
    next_portBOut[`PFMUX_B_ALE] = engAle;
    next_portBOut[`PFMUX_B_WR] = engWrN;
    next_portBOut[`PFMUX_B_HBE] = engHbe;
    next_portBOut[`PFMUX_B_RD] = engRdN;
    next_portBOe = (next_portBOe & ~`PFMUX_B_CTL_MASK) | ({16{~holdAck}} & `PFMUX_B_CTL_MASK);
  end

  // ==========================================
  // registered pin outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      portAOut <= 16'h0000;
      portAOe <= 1'b0;
      portBOut <= 16'h0000;
      portBOe <= 16'h0000;
      portROut <= 8'h00;
      portROe <= 8'h00;
      portDOut <= 8'h00;
      portDOe <= 8'h00;
      holdAcknowledgeOut <= 1'b0;
    end else begin
      portAOut <= engAdOut;
      portAOe <= engAdOe & ~holdAck;
      portBOut <= next_portBOut;
      portBOe <= next_portBOe;
      portROut <= portRData;
      portROe <= portRDir;
      portDOut <= {txTwoData, 1'b0, txOneData, 5'h00};
      portDOe <= {txTwoDrive, 1'b0, txOneDrive, 5'h00};
      holdAcknowledgeOut <= holdAck;
    end
  end

  // ==========================================
  // shared serial pin routing
  always @(posedge clk) begin
    if (sys_rst) begin
      receiverOneEnable <= 1'b0;
      decoderFrameSync <= 1'b0;
      receiverOneClock <= 1'b0;
    end else begin
      receiverOneEnable <= (sharedSel == `PFMUX_D0_ENABLE) &
        portDSync[`PFMUX_D_SHARED];
      decoderFrameSync <= (sharedSel == `PFMUX_D0_FSYNC) &
        portDSync[`PFMUX_D_SHARED];
      receiverOneClock <= (sharedSel == `PFMUX_D0_CLOCK) &
        portDSync[`PFMUX_D_SHARED];
    end
  end

  // ==========================================
  // derived clocks
  assign invertedClockOut = ~clk;

  // toggles every rising edge for half rate
  always @(posedge clk) begin
    if (sys_rst) begin
      halfRateClockOut <= 1'b0;
    end else begin
      halfRateClockOut <= ~halfRateClockOut;
    end
  end
endmodule // pfmux_top

// file: include/pfmux_consts.vh
`ifndef PFMUX_CONSTS_VH
`define PFMUX_CONSTS_VH
// ==========================================
// register byte offsets on the bus
`define PFMUX_OFF_B_DATA 8'h00
`define PFMUX_OFF_B_DIR 8'h04
`define PFMUX_OFF_B_FUNC 8'h08
`define PFMUX_OFF_R_DATA 8'h0c
`define PFMUX_OFF_R_DIR 8'h10
`define PFMUX_OFF_R_PINS 8'h14
`define PFMUX_OFF_I_PINS 8'h18
`define PFMUX_OFF_D_PINS 8'h1c
`define PFMUX_OFF_B_PINS 8'h20
`define PFMUX_OFF_CTRL 8'h24
`define PFMUX_OFF_X_ADDR 8'h28
`define PFMUX_OFF_X_DATA 8'h2c
`define PFMUX_OFF_X_CMD 8'h30
// ==========================================
// field positions
`define PFMUX_CTRL_EXT 0
`define PFMUX_CTRL_BANK_LO 1
`define PFMUX_CTRL_HOLD 5
`define PFMUX_CTRL_D0SEL_LO 6
`define PFMUX_CMD_START 0
`define PFMUX_CMD_WRITE 1
`define PFMUX_CMD_BYTE 2
`define PFMUX_STAT_BUSY 0
`define PFMUX_STAT_HOLDA 1
// ==========================================
// pin positions
`define PFMUX_B_HOLDA 7
`define PFMUX_B_BS0 8
`define PFMUX_B_BS1 9
`define PFMUX_B_ALE 10
`define PFMUX_B_WR 11
`define PFMUX_B_HBE 12
`define PFMUX_B_BS2 13
`define PFMUX_B_BS3 14
`define PFMUX_B_RD 15
`define PFMUX_B_CTL_MASK 16'h9c00
`define PFMUX_I_RDY 4
`define PFMUX_D_SHARED 0
`define PFMUX_D_TX1 5
`define PFMUX_D_TX2 7
// ==========================================
// reset values, modes, timing
`define PFMUX_RST16 16'h0000
`define PFMUX_RST8 8'h00
`define PFMUX_D0_ENABLE 2'h0
`define PFMUX_D0_FSYNC 2'h1
`define PFMUX_D0_CLOCK 2'h2
`define PFMUX_TAIL_CYCLES 2
`endif

// file: src/pfmux_pin_sync.v
// ==========================================
// two-stage synchroniser for pin inputs
module pfmux_pin_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // pins in, synchronised out
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinSync
);
  reg [WIDTH-1:0] stageOne;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (sys_rst) begin
      stageOne <= {WIDTH{1'b0}};
      pinSync <= {WIDTH{1'b0}};
    end else begin
      stageOne <= pinIn;
      pinSync <= stageOne;
    end
  end
endmodule // pfmux_pin_sync

// file: src/pfmux_ext_bus.v
`include "pfmux_consts.vh"
// ==========================================
// multiplexed address/data bus sequencer
module pfmux_ext_bus #(
  parameter TAIL = `PFMUX_TAIL_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // access request
  input wire start,
  input wire writeAcc,
  input wire byteAcc,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire ready,
  input wire [15:0] adIn,
  // status and read data
  output wire busy,
  output reg [15:0] rdata,
  // bus pins before the output stage
  output reg ale,
  output reg readStrobeN,
  output reg writeStrobeN,
  output reg highByteSelect,
  output reg [15:0] adOut,
  output reg adOe
);
  localparam S_IDLE = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_STRB = 4'h4;
  localparam S_TAIL = 4'h8;

  reg [3:0] state;
  reg isWrite;
  reg [15:0] wdataHeld;
  reg [1:0] tailCnt;

  assign busy = ~state[0];

  // address phase, strobe phase, then a tail for the data sync
  always @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      isWrite <= 1'b0;
      wdataHeld <= 16'h0000;
      tailCnt <= 2'h0;
      rdata <= 16'h0000;
      ale <= 1'b0;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
      highByteSelect <= 1'b0;
      adOut <= 16'h0000;
      adOe <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            adOut <= addr;
            adOe <= 1'b1;
            ale <= 1'b1;
            highByteSelect <= ~byteAcc | addr[0];
            isWrite <= writeAcc;
            wdataHeld <= wdata;
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          ale <= 1'b0;
          adOut <= wdataHeld;
          adOe <= isWrite;
          readStrobeN <= isWrite;
          writeStrobeN <= ~isWrite;
          state <= S_STRB;
        end
        S_STRB: begin
          // ready low stretches the strobe
          if (ready) begin
            tailCnt <= 2'h0;
            state <= S_TAIL;
          end
        end
        S_TAIL: begin
          tailCnt <= tailCnt + 2'h1;
          // one extra count covers the two-flop lag on the data pins
          if (tailCnt == TAIL) begin
            if (!isWrite) begin
              rdata <= adIn;
            end
            readStrobeN <= 1'b1;
            writeStrobeN <= 1'b1;
            adOe <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // pfmux_ext_bus

// file: testbench/pfmux_monitor.sv
// ==========================================
// bus and pin checker for the port mux
module pfmux_monitor (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // register bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  // pins
  input logic portAOe,
  input logic [15:0] portBOut,
  input logic [15:0] portBOe,
  input logic [7:0] portROut,
  input logic [7:0] portROe,
  input logic holdAcknowledgeOut,
  input logic halfRateClockOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadow of the control byte, taken at the write edge
  always @(posedge clk) begin
    if (sys_rst) ctrl <= 8'h00;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h24 && wb_sel_i[0])
      ctrl <= wb_dat_i[7:0];
  end
  // ==========================================
  // assertions
  a_half_rate: assert property (!$past(sys_rst) |-> halfRateClockOut != $past(halfRateClockOut))
    else $error("half rate clock did not toggle");
  a_strobes_driven: assert property (!$past(sys_rst) && !holdAcknowledgeOut
    && !$past(holdAcknowledgeOut) |-> (portBOe & 16'h9c00) == 16'h9c00)
    else $error("bus strobes not driven");
  a_ale_single: assert property (portBOut[10] |=> !portBOut[10])
    else $error("address strobe longer than one cycle");
  a_rd_after_ale: assert property ($fell(portBOut[15]) && !$past(sys_rst) |-> $past(portBOut[10]))
    else $error("read strobe without address phase");
  a_write_drives: assert property (!portBOut[11] && portBOe[11] |-> portAOe)
    else $error("data not driven during write");
  a_read_releases: assert property (!portBOut[15] && portBOe[15] |-> !portAOe)
    else $error("bus driven during read");
  a_dir_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[0]
    |=> portROe == $past(wb_dat_i[7:0]))
    else $error("direction write not applied");
  a_data_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h0c && wb_sel_i[0]
    |=> portROut == $past(wb_dat_i[7:0]))
    else $error("data write not applied");
  a_bank_out: assert property (ctrl[0] && ctrl == $past(ctrl) && ctrl == $past(ctrl, 2)
    |-> {portBOut[14], portBOut[13], portBOut[9], portBOut[8]} == ctrl[4:1])
    else $error("bank number wrong on port pins");
  a_hold_float: assert property (holdAcknowledgeOut && $past(holdAcknowledgeOut)
    |-> !portAOe && (portBOe & 16'h9c00) == 16'h0000)
    else $error("bus driven while hold acknowledged");
endmodule // pfmux_monitor

bind pfmux_top pfmux_monitor pfmux_monitor_inst (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .portAOe(portAOe),
  .portBOut(portBOut), .portBOe(portBOe), .portROut(portROut), .portROe(portROe),
  .holdAcknowledgeOut(holdAcknowledgeOut), .halfRateClockOut(halfRateClockOut));

// file: testbench/pfmux_ext_mem.sv
// ==========================================
// external memory on the multiplexed bus
module pfmux_ext_mem (
  // clock
  input logic clk,
  // wire levels
  input logic [15:0] adPins,
  input logic ale,
  input logic readN,
  input logic writeN,
  input logic highSel,
  input logic slow,
  // answers
  output logic [15:0] adDrive,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [15:0] latAddr;
  logic latHigh;
  logic [15:0] lastPins = 16'h0000;
  logic [3:0] lowCnt = 4'h0;
  // latch address and byte select, store written lanes
  always @(posedge clk) begin
    lastPins <= adPins;
    lowCnt <= (!readN || !writeN) ? lowCnt + 4'h1 : 4'h0;
    if (ale) begin
      latAddr <= adPins;
      latHigh <= highSel;
    end
    if (!writeN && !latAddr[0]) mem[latAddr[8:1]][7:0] <= adPins[7:0];
    if (!writeN && latHigh) mem[latAddr[8:1]][15:8] <= adPins[15:8];
  end
  // released bus shows the inverse of its last level
  assign adDrive = !readN ? mem[latAddr[8:1]] : ~lastPins;
  assign ready = !slow || lowCnt >= 4'h3;
endmodule // pfmux_ext_mem

// file: testbench/port_pin_function_mux_tb.sv
// ==========================================
// port mux testbench
module port_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, portAOe, holdAcknowledgeOut;
  logic readyOrHoldRequest, txOneData, txOneDrive, txTwoData, txTwoDrive;
  logic receiverOneEnable, decoderFrameSync, receiverOneClock, invertedClockOut, halfRateClockOut;
  logic [7:0] wb_adr_i, portIIn, portISync, portDIn, portDOut, portDOe, portDSync;
  logic [7:0] portRIn, portROut, portROe, rExt, dExt;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] portAIn, portAOut, portBIn, portBOut, portBOe, altOut, altOe, portBSync;
  logic [15:0] bExt, memDrive;
  logic memReady, slow, holdReq, holdMode, h;
  int error_cnt = 0;
  int checks = 0;
  pfmux_top pfmux_top_inst (.*);
  pfmux_ext_mem pfmux_ext_mem_inst (.clk(clk), .adPins(portAIn), .ale(portBOe[10] & portBOut[10]),
    .readN(~portBOe[15] | portBOut[15]), .writeN(~portBOe[11] | portBOut[11]),
    .highSel(portBOut[12]), .slow(slow), .adDrive(memDrive), .ready(memReady));
  // wire levels from all drivers
  assign portAIn = portAOe ? portAOut : memDrive;
  assign portBIn = (portBOe & portBOut) | (~portBOe & bExt);
  assign portRIn = (portROe & portROut) | (~portROe & rExt);
  assign portDIn = (portDOe & portDOut) | (~portDOe & dExt);
  assign readyOrHoldRequest = holdMode ? holdReq : memReady;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("bus ack", {31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    wbx(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask
  task automatic xacc(input logic [15:0] a, input logic [15:0] d, input logic [2:0] cmd);
    int n;
    wbx(1'b1, 8'h28, {16'h0, a});
    wbx(1'b1, 8'h2c, {16'h0, d});
    wbx(1'b1, 8'h30, {29'h0, cmd});
    n = 0;
    do begin
      wbx(1'b0, 8'h30, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
    chk("access done", {31'h0, q[0]}, 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // stimulus
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, txOneData, txOneDrive, txTwoData, txTwoDrive} = 7'h00;
    {wb_adr_i, wb_dat_i, altOut, altOe} = 72'h0;
    wb_sel_i = 4'hf;
    {slow, holdReq, holdMode} = 3'b000;
    {bExt, rExt, dExt, portIIn} = {16'h5a5a, 8'h3c, 8'h7b, 8'h96};
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    h = halfRateClockOut;
    chk("inverted clock", {31'h0, invertedClockOut}, 32'h0);
    @(posedge clk);
    #1;
    chk("half clock", {31'h0, halfRateClockOut}, {31'h0, ~h});
    // bidirectional port and register map
    wbx(1'b1, 8'h10, 32'h0f);
    wbx(1'b1, 8'h0c, 32'ha5);
    chk("dir out", {24'h0, portROe}, 32'h0f);
    rdc("dir reg", 8'h10, 32'h0f);
    rdc("data reg", 8'h0c, 32'ha5);
    rdc("r pins", 8'h14, 32'h35);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test port r done");
    // input ports and transmit outputs
    {txOneDrive, txOneData} <= 2'b11;
    rdc("i pins", 8'h18, 32'h96);
    chk("i sync", {24'h0, portISync}, 32'h96);
    chk("tx1 out", {30'h0, portDOe[5], portDOut[5]}, 32'h3);
    {txOneDrive, txOneData} <= 2'b00;
    rdc("d pins", 8'h1c, 32'h7b);
    for (int s = 0; s < 3; s++) begin
      wbx(1'b1, 8'h24, s << 6);
      rdc("ctrl", 8'h24, s << 6);
      chk("d0 route", {receiverOneClock, decoderFrameSync, receiverOneEnable}, 1 << s);
    end
    $display("test ports i d done");
    // general port alternate functions and bank outputs
    altOut <= 16'h000a;
    altOe <= 16'h0005;
    wbx(1'b1, 8'h04, 32'h00f0);
    wbx(1'b1, 8'h00, 32'h0055);
    wbx(1'b1, 8'h08, 32'h000f);
    rdc("func reg", 8'h08, 32'h000f);
    chk("b out", {24'h0, portBOut[7:0]}, 32'h5a);
    chk("b oe", {24'h0, portBOe[7:0]}, 32'hf5);
    rdc("b pins", 8'h20, 32'hca5a);
    for (int i = 0; i < 4; i++) begin
      wbx(1'b1, 8'h24, ((1 << i) << 1) | 1);
      rdc("ctrl", 8'h24, ((1 << i) << 1) | 1);
      chk("bank", {portBOut[14], portBOut[13], portBOut[9], portBOut[8]}, 1 << i);
    end
    wbx(1'b1, 8'h24, 32'h0);
    $display("test port b done");
    // external accesses, prompt and slow
    xacc(16'h0010, 16'h1234, 3'h3);
    chk("latched addr", pfmux_ext_mem_inst.latAddr, 32'h0010);
    chk("word select", pfmux_ext_mem_inst.latHigh, 32'h1);
    chk("mem word", pfmux_ext_mem_inst.mem[8], 32'h1234);
    slow <= 1'b1;
    xacc(16'h0012, 16'habcd, 3'h3);
    xacc(16'h0012, 16'h0000, 3'h1);
    rdc("slow read", 8'h2c, 32'habcd);
    slow <= 1'b0;
    xacc(16'h0010, 16'h0000, 3'h1);
    rdc("fast read", 8'h2c, 32'h1234);
    xacc(16'h0021, 16'h00ee, 3'h7);
    chk("odd byte select", pfmux_ext_mem_inst.latHigh, 32'h1);
    xacc(16'h0020, 16'h00ee, 3'h7);
    chk("even byte select", pfmux_ext_mem_inst.latHigh, 32'h0);
    $display("test external bus done");
    // hold request
    wbx(1'b1, 8'h24, 32'h20);
    holdMode <= 1'b1;
    holdReq <= 1'b1;
    repeat (3) wbx(1'b0, 8'h30, 32'h0);
    chk("hold status", {31'h0, q[1]}, 32'h1);
    chk("hold pin", {31'h0, holdAcknowledgeOut}, 32'h1);
    chk("port a float", {31'h0, portAOe}, 32'h0);
    holdReq <= 1'b0;
    repeat (3) wbx(1'b0, 8'h30, 32'h0);
    chk("hold released", {31'h0, q[1]}, 32'h0);
    $display("test hold done");
    wrap_up();
  end
  // watchdog against a hung access
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule // port_pin_function_mux_tb
